// ==== verilog/usb_term_ctrl.sv ====
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module usb_term_ctrl (
  input  wire logic        clk,            // 100 MHz clock
  input  wire logic        rst,            // Synchronous reset, active high
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        resetNInput,    // Reset pin, active low
  input  wire logic        hsRxData,       // HS receiver serial data
  input  wire logic        hsSquelch,      // HS squelch, high when no signal
  input  wire logic        fsRxData,       // FS/LS differential receiver data
  input  wire logic        seRxPlus,       // Single-ended receiver, plus line
  input  wire logic        seRxMinus,      // Single-ended receiver, minus line
  output logic             plusPullupOn,   // 1.5k plus-line pull-up
  output logic             minusPullupOn,  // 1.5k minus-line pull-up
  output logic             plusPulldownOn, // 15k plus-line pulldown
  output logic             minusPulldownOn,// 15k minus-line pulldown
  output logic             hsTermOn,       // 45 ohm HS termination
  output logic             hsTxOe,         // HS transmitter enable
  output logic             fsTxOe,         // FS/LS transmitter enable
  output logic             txSerial,       // NRZI line level to transmitter
  output logic      [2:0]  driveBoost,     // HS amplitude adjust
  output logic      [2:0]  rxSensitivity   // HS squelch threshold lowering
);
  // Configuration registers
  logic [1:0] xcvr_r, xcvr_nxt;
  logic       term_r, term_nxt;
  logic [1:0] opSel_r, opSel_nxt;
  logic       plusPd_r, plusPd_nxt, minusPd_r, minusPd_nxt;
  logic [2:0] boost_r, boost_nxt, sense_r, sense_nxt;
  // Bus answer registers
  logic        pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  // Outputs
  logic [4:0] termOut_r, termOut_nxt;
  logic       hsTxOe_r, hsTxOe_nxt, fsTxOe_r, fsTxOe_nxt;
  logic [1:0] lineState_r, lineState_nxt;
  // Receive
  logic       rxPrev_r, rxPrev_nxt;
  logic [2:0] rxOnes_r, rxOnes_nxt;
  logic [2:0] rxCnt_r, rxCnt_nxt;
  logic [7:0] rxShift_r, rxShift_nxt, rxByte_r, rxByte_nxt;
  logic       rxFull_r, rxFull_nxt;
  // Transmit
  usb_term_pkg::tx_state_t txState_r, txState_nxt;
  logic [7:0] txShift_r, txShift_nxt;
  logic [3:0] txLeft_r, txLeft_nxt;
  logic [2:0] txOnes_r, txOnes_nxt;
  logic       txLevel_r, txLevel_nxt;

  logic [4:0]  termDec;
  logic        access, commit, wrCommit, rdCommit, mapped;
  logic        hsMode, driveOk, rxBit, rxTake, rxData;
  logic [31:0] rdValue;

  function automatic logic hitReg(input logic [7:0] addr, input logic [7:0] ofs);
    hitReg = (addr == ofs);
  endfunction

  usb_term_decode usb_term_decode_inst (
    .xcvrSel    (xcvr_r),
    .termSel    (term_r),
    .opSel      (opSel_r),
    .plusPdReq  (plusPd_r),
    .minusPdReq (minusPd_r),
    .termVec    (termDec)
  );

  // APB slave: one wait state, commit at the edge that sees pready
  always_comb begin
    access   = psel && penable;
    commit   = access && pready_r;
    wrCommit = commit && pwrite;
    rdCommit = commit && !pwrite;
    mapped   = hitReg(paddr, usb_term_pkg::FUNC_CTRL_OFS)
            || hitReg(paddr, usb_term_pkg::OTG_CTRL_OFS)
            || hitReg(paddr, usb_term_pkg::HS_COMP_OFS)
            || hitReg(paddr, usb_term_pkg::TX_DATA_OFS)
            || hitReg(paddr, usb_term_pkg::STATUS_OFS);
    rdValue = 32'h0;
    case (paddr)
      usb_term_pkg::FUNC_CTRL_OFS: begin
        rdValue[usb_term_pkg::XCVR_POS +: 2]  = xcvr_r;
        rdValue[usb_term_pkg::TERM_POS]       = term_r;
        rdValue[usb_term_pkg::OPSEL_POS +: 2] = opSel_r;
      end
      usb_term_pkg::OTG_CTRL_OFS: begin
        rdValue[usb_term_pkg::PLUS_PD_POS]  = plusPd_r;
        rdValue[usb_term_pkg::MINUS_PD_POS] = minusPd_r;
      end
      usb_term_pkg::HS_COMP_OFS: begin
        rdValue[usb_term_pkg::BOOST_POS +: 3] = boost_r;
        rdValue[usb_term_pkg::SENSE_POS +: 3] = sense_r;
      end
      usb_term_pkg::TX_DATA_OFS: begin
        rdValue[usb_term_pkg::ST_TXBUSY_POS] = (txState_r != usb_term_pkg::TX_IDLE);
      end
      usb_term_pkg::STATUS_OFS: begin
        rdValue[usb_term_pkg::ST_TERM_POS +: 5]   = termOut_r;
        rdValue[usb_term_pkg::ST_LINE_POS +: 2]   = lineState_r;
        rdValue[usb_term_pkg::ST_SQUELCH_POS]     = hsSquelch;
        rdValue[usb_term_pkg::ST_RXBYTE_POS +: 8] = rxByte_r;
        rdValue[usb_term_pkg::ST_RXFULL_POS]      = rxFull_r;
        rdValue[usb_term_pkg::ST_TXBUSY_POS]      = (txState_r != usb_term_pkg::TX_IDLE);
      end
      default: rdValue = 32'h0;
    endcase
    pready_nxt  = access && !pready_r;
    prdata_nxt  = (access && !pready_r && !pwrite) ? rdValue : 32'h0;
    pslverr_nxt = access && !pready_r && !mapped;
  end

  // Settings registers
  always_comb begin
    xcvr_nxt    = xcvr_r;
    term_nxt    = term_r;
    opSel_nxt   = opSel_r;
    plusPd_nxt  = plusPd_r;
    minusPd_nxt = minusPd_r;
    boost_nxt   = boost_r;
    sense_nxt   = sense_r;
    if (wrCommit && hitReg(paddr, usb_term_pkg::FUNC_CTRL_OFS)) begin
      xcvr_nxt  = pwdata[usb_term_pkg::XCVR_POS +: 2];
      term_nxt  = pwdata[usb_term_pkg::TERM_POS];
      opSel_nxt = pwdata[usb_term_pkg::OPSEL_POS +: 2];
    end
    if (wrCommit && hitReg(paddr, usb_term_pkg::OTG_CTRL_OFS)) begin
      plusPd_nxt  = pwdata[usb_term_pkg::PLUS_PD_POS];
      minusPd_nxt = pwdata[usb_term_pkg::MINUS_PD_POS];
    end
    if (wrCommit && hitReg(paddr, usb_term_pkg::HS_COMP_OFS)) begin
      boost_nxt = pwdata[usb_term_pkg::BOOST_POS +: 3];
      sense_nxt = pwdata[usb_term_pkg::SENSE_POS +: 3];
    end
  end

  // Kept apart so the transmit and output blocks form no loop
  always_comb begin
    hsMode  = (xcvr_r == usb_term_pkg::XCVR_HS);
    driveOk = resetNInput && (opSel_r != usb_term_pkg::OP_TRISTATE);
  end

  // Termination and line outputs
  always_comb begin
    termOut_nxt = resetNInput ? termDec : usb_term_pkg::TERM_NONE;
    hsTxOe_nxt  = driveOk && hsMode && (txState_nxt != usb_term_pkg::TX_IDLE);
    fsTxOe_nxt  = driveOk && !hsMode && (txState_nxt != usb_term_pkg::TX_IDLE);
    lineState_nxt = {seRxMinus, seRxPlus};
  end

  // Receive path: mux, squelch gate, NRZI decode, destuff
  always_comb begin
    rxBit = hsMode ? hsRxData : fsRxData;
    rxTake = hsMode ? !hsSquelch : 1'b1;
    rxData = (rxBit == rxPrev_r);
    rxPrev_nxt  = rxTake ? rxBit : rxPrev_r;
    rxOnes_nxt  = rxOnes_r;
    rxCnt_nxt   = rxCnt_r;
    rxShift_nxt = rxShift_r;
    rxByte_nxt  = rxByte_r;
    rxFull_nxt  = rxFull_r;
    if (rdCommit && hitReg(paddr, usb_term_pkg::STATUS_OFS)) begin
      rxFull_nxt = 1'b0;
    end
    if (rxTake) begin
      if (rxOnes_r == 3'(usb_term_pkg::STUFF_LIMIT) && !rxData) begin
        rxOnes_nxt = 3'h0;
      end else begin
        rxOnes_nxt  = rxData ? 3'(rxOnes_r + 3'h1) : 3'h0;
        rxShift_nxt = {rxData, rxShift_r[7:1]};
        rxCnt_nxt   = 3'(rxCnt_r + 3'h1);
        if (rxCnt_r == 3'h7) begin
          rxByte_nxt = {rxData, rxShift_r[7:1]};
          // Set wins over a same-cycle status read
          rxFull_nxt = 1'b1;
        end
      end
    end
  end

  // Transmit path
  always_comb begin
    txState_nxt = txState_r;
    txShift_nxt = txShift_r;
    txLeft_nxt  = txLeft_r;
    txOnes_nxt  = txOnes_r;
    txLevel_nxt = txLevel_r;
    case (txState_r)
      usb_term_pkg::TX_IDLE: begin
        txOnes_nxt = 3'h0;
        if (wrCommit && hitReg(paddr, usb_term_pkg::TX_DATA_OFS) && driveOk) begin
          txShift_nxt = pwdata[7:0];
          txLeft_nxt  = 4'h8;
          txState_nxt = usb_term_pkg::TX_SHIFT;
        end
      end
      usb_term_pkg::TX_SHIFT: begin
        txShift_nxt = {1'b0, txShift_r[7:1]};
        txLeft_nxt  = 4'(txLeft_r - 4'h1);
        if (txShift_r[0]) begin
          txOnes_nxt = 3'(txOnes_r + 3'h1);
        end else begin
          txOnes_nxt  = 3'h0;
          txLevel_nxt = !txLevel_r;
        end
        if (txShift_r[0] && txOnes_r == 3'(usb_term_pkg::STUFF_LIMIT - 1)) begin
          txState_nxt = usb_term_pkg::TX_STUFF;
        end else if (txLeft_r == 4'h1) begin
          txState_nxt = usb_term_pkg::TX_IDLE;
        end
      end
      usb_term_pkg::TX_STUFF: begin
        txOnes_nxt  = 3'h0;
        txLevel_nxt = !txLevel_r;
        txState_nxt = (txLeft_r == 4'h0) ? usb_term_pkg::TX_IDLE : usb_term_pkg::TX_SHIFT;
      end
      default: txState_nxt = usb_term_pkg::TX_IDLE;
    endcase
    // Dropping drive aborts a frame rather than leaving a stuck line
    if (!driveOk) begin
      txState_nxt = usb_term_pkg::TX_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      xcvr_r      <= usb_term_pkg::XCVR_RST;
      term_r      <= usb_term_pkg::TERM_RST;
      opSel_r     <= usb_term_pkg::OPSEL_RST;
      plusPd_r    <= usb_term_pkg::PD_RST[usb_term_pkg::PLUS_PD_POS];
      minusPd_r   <= usb_term_pkg::PD_RST[usb_term_pkg::MINUS_PD_POS];
      boost_r     <= usb_term_pkg::BOOST_RST;
      sense_r     <= usb_term_pkg::SENSE_RST;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
      prdata_r    <= 32'h0;
      termOut_r   <= usb_term_pkg::TERM_NONE;
      hsTxOe_r    <= 1'b0;
      fsTxOe_r    <= 1'b0;
      lineState_r <= 2'h0;
      rxPrev_r    <= 1'b1;
      rxOnes_r    <= 3'h0;
      rxCnt_r     <= 3'h0;
      rxShift_r   <= 8'h00;
      rxByte_r    <= 8'h00;
      rxFull_r    <= 1'b0;
      txState_r   <= usb_term_pkg::TX_IDLE;
      txShift_r   <= 8'h00;
      txLeft_r    <= 4'h0;
      txOnes_r    <= 3'h0;
      txLevel_r   <= 1'b1;
    end else begin
      xcvr_r      <= xcvr_nxt;
      term_r      <= term_nxt;
      opSel_r     <= opSel_nxt;
      plusPd_r    <= plusPd_nxt;
      minusPd_r   <= minusPd_nxt;
      boost_r     <= boost_nxt;
      sense_r     <= sense_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
      prdata_r    <= prdata_nxt;
      termOut_r   <= termOut_nxt;
      hsTxOe_r    <= hsTxOe_nxt;
      fsTxOe_r    <= fsTxOe_nxt;
      lineState_r <= lineState_nxt;
      rxPrev_r    <= rxPrev_nxt;
      rxOnes_r    <= rxOnes_nxt;
      rxCnt_r     <= rxCnt_nxt;
      rxShift_r   <= rxShift_nxt;
      rxByte_r    <= rxByte_nxt;
      rxFull_r    <= rxFull_nxt;
      txState_r   <= txState_nxt;
      txShift_r   <= txShift_nxt;
      txLeft_r    <= txLeft_nxt;
      txOnes_r    <= txOnes_nxt;
      txLevel_r   <= txLevel_nxt;
    end
  end

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign plusPullupOn    = termOut_r[4];
  assign minusPullupOn   = termOut_r[3];
  assign plusPulldownOn  = termOut_r[2];
  assign minusPulldownOn = termOut_r[1];
  assign hsTermOn        = termOut_r[0];
  assign hsTxOe          = hsTxOe_r;
  assign fsTxOe          = fsTxOe_r;
  assign txSerial        = txLevel_r;
  assign driveBoost      = boost_r;
  assign rxSensitivity   = sense_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_tristate_opsel: assert property (
    opSel_r == usb_term_pkg::OP_TRISTATE |=> termOut_r == 5'h00 && !hsTxOe_r && !fsTxOe_r)
    else $error("tri-state setting left an enable on");
  chk_powerup_pulldowns: assert property (
    !rst && resetNInput && xcvr_r == 2'h1 && !term_r && opSel_r == 2'h0 && plusPd_r && minusPd_r
    |=> termOut_r == 5'h06) else $error("power-up setting wrong");
  chk_host_hs_term: assert property (
    resetNInput && plusPd_r && minusPd_r && xcvr_r == 2'h0 && !term_r && !opSel_r[0]
    |=> termOut_r == 5'h07) else $error("host HS termination missing");
  chk_host_no_pullup: assert property (
    !rst && resetNInput && plusPd_r && minusPd_r && opSel_r != 2'h1
    |=> termOut_r[4:3] == 2'h0 && termOut_r[2:1] == 2'h3) else $error("host pull state wrong");
  chk_periph_fs_pullup: assert property (
    resetNInput && !plusPd_r && !minusPd_r && term_r && xcvr_r == 2'h1 && !opSel_r[0]
    |=> termOut_r == 5'h10) else $error("peripheral FS pull-up wrong");
  chk_periph_ls_pullup: assert property (
    resetNInput && !plusPd_r && !minusPd_r && term_r && xcvr_r == 2'h2 && !opSel_r[0]
    |=> termOut_r == 5'h08) else $error("peripheral LS pull-up wrong");
  chk_periph_hs_term: assert property (
    resetNInput && !plusPd_r && !minusPd_r && !term_r && xcvr_r == 2'h0 && !opSel_r[0]
    |=> termOut_r == 5'h01) else $error("peripheral HS termination wrong");
  chk_connect_detect: assert property (
    resetNInput && !plusPd_r && minusPd_r && !term_r && xcvr_r == 2'h1 && opSel_r == 2'h0
    |=> termOut_r == 5'h02) else $error("connect detect setting wrong");
  chk_reset_pin_off: assert property (
    !resetNInput |=> termOut_r == 5'h00 ##1 !hsTxOe_r && !fsTxOe_r)
    else $error("drivers not tri-stated under reset pin");
  chk_squelch_gate: assert property (
    hsMode && hsSquelch |=> rxCnt_r == $past(rxCnt_r) && rxOnes_r == $past(rxOnes_r))
    else $error("squelched noise reached receive logic");
  chk_tx_stuffing: assert property (
    txState_r == usb_term_pkg::TX_STUFF |-> $past(txOnes_r) == 3'h5 && txOnes_r == 3'h6)
    else $error("stuff bit not after six ones");
  chk_write_settle: assert property (
    $changed(termOut_r) |-> $past(wrCommit, 2) || !$past(resetNInput) || $rose(resetNInput)
    || $past(resetNInput) != $past(resetNInput, 2) || $past(rst, 2))
    else $error("enables changed without a write");

  cov_host_hs: cover property (termOut_r == 5'h07);
  cov_periph_fs: cover property (termOut_r == 5'h10);
  cov_tx_stuff: cover property (txState_r == usb_term_pkg::TX_STUFF);
  cov_rx_byte: cover property ($rose(rxFull_r));
endmodule

// ==== verilog/usb_term_pkg.sv ====
package usb_term_pkg;
  localparam logic [7:0] FUNC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] OTG_CTRL_OFS    = 8'h04;
  localparam logic [7:0] HS_COMP_OFS     = 8'h08;
  localparam logic [7:0] TX_DATA_OFS     = 8'h0c;
  localparam logic [7:0] STATUS_OFS      = 8'h10;
  // FUNC_CTRL fields
  localparam int XCVR_POS = 0;
  localparam int TERM_POS = 2;
  localparam int OPSEL_POS = 3;
  // OTG_CTRL fields
  localparam int PLUS_PD_POS = 0;
  localparam int MINUS_PD_POS = 1;
  // HS_COMP fields
  localparam int BOOST_POS = 0;
  localparam int SENSE_POS = 4;
  // STATUS fields
  localparam int ST_TERM_POS = 0;
  localparam int ST_LINE_POS = 5;
  localparam int ST_SQUELCH_POS = 7;
  localparam int ST_RXBYTE_POS = 8;
  localparam int ST_RXFULL_POS = 16;
  localparam int ST_TXBUSY_POS = 17;
  // Reset values: power-up termination setting
  localparam logic [1:0] XCVR_RST = 2'h1;
  localparam logic       TERM_RST = 1'h0;
  localparam logic [1:0] OPSEL_RST = 2'h0;
  localparam logic [1:0] PD_RST = 2'h3;
  localparam logic [2:0] BOOST_RST = 3'h0;
  localparam logic [2:0] SENSE_RST = 3'h0;
  // Settings encodings
  localparam logic [1:0] XCVR_HS = 2'h0;
  localparam logic [1:0] XCVR_FS = 2'h1;
  localparam logic [1:0] XCVR_LS = 2'h2;
  localparam logic [1:0] OP_NORMAL = 2'h0;
  localparam logic [1:0] OP_TRISTATE = 2'h1;
  localparam logic [1:0] OP_NODRIVE = 2'h2;
  // Termination vector {plusPu, minusPu, plusPd, minusPd, hsTerm}
  localparam logic [4:0] TERM_NONE = 5'h00;
  localparam logic [4:0] TERM_PD_BOTH = 5'h06;
  localparam logic [4:0] TERM_HOST_HS = 5'h07;
  localparam logic [4:0] TERM_PLUS_PU = 5'h10;
  localparam logic [4:0] TERM_MINUS_PU = 5'h08;
  localparam logic [4:0] TERM_HS_ONLY = 5'h01;
  localparam logic [4:0] TERM_MINUS_PD = 5'h02;
  localparam int STUFF_LIMIT = 6;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STUFF = 3'b100
  } tx_state_t;
endpackage

// ==== verilog/usb_term_decode.sv ====
`timescale 1ns/1ps
module usb_term_decode (
  input  wire logic [1:0] xcvrSel,   // Transceiver speed select
  input  wire logic       termSel,   // Termination choice
  input  wire logic [1:0] opSel,     // Operating select
  input  wire logic       plusPdReq, // Plus-line pulldown request
  input  wire logic       minusPdReq,// Minus-line pulldown request
  output logic      [4:0] termVec    // {plusPu, minusPu, plusPd, minusPd, hsTerm}
);
  logic opRun;
  always_comb begin
    opRun = (opSel == usb_term_pkg::OP_NORMAL) || (opSel == usb_term_pkg::OP_NODRIVE);
    termVec = usb_term_pkg::TERM_PD_BOTH;
    if (opSel == usb_term_pkg::OP_TRISTATE) begin
      termVec = usb_term_pkg::TERM_NONE;
    end else if (plusPdReq && minusPdReq) begin
      termVec = usb_term_pkg::TERM_PD_BOTH;
      if (xcvrSel == usb_term_pkg::XCVR_HS && !termSel && opRun) begin
        termVec = usb_term_pkg::TERM_HOST_HS;
      end
      // power-up gives pulldowns, already the host default
    end else if (!plusPdReq) begin
      if (termSel && opRun && xcvrSel == usb_term_pkg::XCVR_HS
          && opSel == usb_term_pkg::OP_NODRIVE) begin
        termVec = usb_term_pkg::TERM_PLUS_PU;
      end else if (termSel && opRun && xcvrSel == usb_term_pkg::XCVR_FS) begin
        termVec = usb_term_pkg::TERM_PLUS_PU;
      end else if (termSel && opRun && xcvrSel == usb_term_pkg::XCVR_LS && !minusPdReq) begin
        termVec = usb_term_pkg::TERM_MINUS_PU;
      end else if (!termSel && opRun && xcvrSel == usb_term_pkg::XCVR_HS) begin
        termVec = usb_term_pkg::TERM_HS_ONLY;
      end else if (!termSel && minusPdReq && xcvrSel == usb_term_pkg::XCVR_FS
                   && opSel == usb_term_pkg::OP_NORMAL) begin
        termVec = usb_term_pkg::TERM_NONE;
      end
      if (minusPdReq && termVec != usb_term_pkg::TERM_PD_BOTH) begin
        termVec = termVec | usb_term_pkg::TERM_MINUS_PD;
      end
    end
  end
endmodule

// ==== verif/link_master.sv ====
`timescale 1ns/1ps
// Link side of the settings bus: one APB master, idle between transfers
module link_master (
  input  wire logic        clk,     // Clock
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Direction
  output logic      [7:0]  paddr,   // Byte address
  output logic      [31:0] pwdata,  // Write data
  input  wire logic        pready   // Ready
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // Held until ready is seen at an edge; only the bench timeout ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// ==== verif/usb_term_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module usb_term_ctrl_tb;
  typedef struct {logic [32:0] e; logic [32:0] m;} note_t;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, resetNInput, hsSquelch;
  logic        plusPullupOn, minusPullupOn, plusPulldownOn, minusPulldownOn, hsTermOn;
  logic        hsTxOe, fsTxOe, txSerial;
  logic [2:0]  driveBoost, rxSensitivity;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          mismatches, comparisons, cycles, seed, i, n;
  note_t       q[$];
  note_t       nt;
  // {func_ctrl[4:0], otg_ctrl[1:0], expected enables}
  logic [11:0] tbl[16] = '{12'h760, 12'h0e6, 12'h067, 12'h867, 12'h3e6, 12'hb66,
    12'ha10, 12'h290, 12'hb08, 12'h001, 12'h801, 12'h043, 12'h2d2, 12'h0c2,
    12'hce6, 12'h2a6};
  always #5 clk = ~clk;
  usb_term_ctrl usb_term_ctrl_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .resetNInput, .hsRxData(1'h0),
    .hsSquelch, .fsRxData(1'h1), .seRxPlus(1'h1), .seRxMinus(1'h0),
    .plusPullupOn, .minusPullupOn, .plusPulldownOn, .minusPulldownOn, .hsTermOn,
    .hsTxOe, .fsTxOe, .txSerial, .driveBoost, .rxSensitivity);
  link_master link_master_inst (.clk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready);
  task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
    q.push_back('{e, m});
    link_master_inst.xfer(1'h0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    link_master_inst.xfer(1'h1, a, d);
  endtask
  // Sends one byte and counts drive cycles and line toggles
  task automatic tx_byte(input logic [31:0] d, input int eFs, input int eHs, input int eTog);
    logic p;
    int   f, s, t;
    f = 0;
    s = 0;
    t = 0;
    wr(8'h0c, d);
    p = txSerial;
    for (int k = 0; k < 30; k++) begin
      @(posedge clk);
      f += (fsTxOe === 1'h1) ? 1 : 0;
      s += (hsTxOe === 1'h1) ? 1 : 0;
      t += (txSerial !== p) ? 1 : 0;
      p = txSerial;
    end
    `CHK("fs tx cycles", eFs, f)
    `CHK("hs tx cycles", eHs, s)
    `CHK("tx toggles", eTog, t)
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read results land in the pready cycle
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      mismatches++;
      end_sim();
    end
    if (psel && penable && pready === 1'h1 && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      `CHK("read", nt.e & nt.m, {pslverr, prdata} & nt.m)
    end
  end
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    resetNInput = 1'h1;
    hsSquelch = 1'h1;
    seed = 39;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd(8'h00, 33'h1, '1);
    rd(8'h04, 33'h3, '1);
    rd(8'h10, 33'ha6, 33'hff);
    rd(8'h14, {1'h1, 32'h0}, '1);
    for (i = 0; i < 16; i++) begin
      wr(8'h00, {27'h0, tbl[i][11:7]});
      wr(8'h04, {30'h0, tbl[i][6:5]});
      rd(8'h10, {28'h0, tbl[i][4:0]}, 33'h1f);
    end
    for (i = 0; i < 3; i++) begin
      n = $random(seed) & 32'h77;
      wr(8'h08, n);
      rd(8'h08, {1'h0, n}, '1);
      `CHK("boost", n[2:0], driveBoost)
      `CHK("sense", n[6:4], rxSensitivity)
    end
    resetNInput <= 1'h0;
    repeat (2) @(posedge clk);
    `CHK("enables", 5'h0, {plusPullupOn, minusPullupOn, plusPulldownOn,
      minusPulldownOn, hsTermOn})
    resetNInput <= 1'h1;
    wr(8'h00, 32'h5);
    wr(8'h04, 32'h0);
    // Six ones force one stuffed toggle
    tx_byte(32'h3f, 9, 0, 3);
    wr(8'h00, 32'h0);
    tx_byte(32'h00, 0, 8, 8);
    // Byte taken from the FS stream before the switch
    rd(8'h10, 33'h10080, 33'h10080);
    rd(8'h10, 33'h00080, 33'h10080);
    hsSquelch <= 1'h0;
    repeat (12) @(posedge clk);
    rd(8'h10, 33'h10000, 33'h10080);
    end_sim();
  end
endmodule
